// File: design/szbt_regs.svh
// Register offsets, field positions, reset values and access lengths
// Included by the timing block, the checker and the bench; definitions only
`ifndef SZBT_REGS_SVH
`define SZBT_REGS_SVH

// ==========================================
// Register offsets (byte addresses)
`define SZBT_EWR_OFS 17'h0f900
`define SZBT_IO_ZONE_TIMING_CONFIG_OFS 17'h0f902
`define SZBT_Z0CFG_OFS 17'h0f904
`define SZBT_Z1CFG_OFS 17'h0f906

// ==========================================
// Reset values
`define SZBT_ZCFG_RST 16'h069f
`define SZBT_EWR_RST 8'h07

// ==========================================
// Field positions inside a zone configuration word
`define SZBT_WAIT_LO 0
`define SZBT_HOLD_LO 3
`define SZBT_BW_BIT 7
`define SZBT_POST_IDLE_ENABLE_BIT 9
`define SZBT_PRELIMINARY_IDLE_ENABLE_BIT 10
`define SZBT_FRE_BIT 11
`define SZBT_ZCFG_WMASK 16'h0e9f
`define SZBT_EWR_BIT 0

// ==========================================
// Address ranges
`define SZBT_FLASH_LO_END 17'h0bfff
`define SZBT_FLASH_HI_BEG 17'h1c000
`define SZBT_FLASH_HI_END 17'h1ffff
`define SZBT_RAM_BEG 17'h0c000
`define SZBT_RAM_END 17'h0cbff
`define SZBT_BOOT_BEG 17'h0e000
`define SZBT_BOOT_END 17'h0e5ff
`define SZBT_EEP_BEG 17'h0f000
`define SZBT_EEP_END 17'h0f27f
`define SZBT_PER0_BEG 17'h0f800
`define SZBT_PER0_END 17'h0faff
`define SZBT_IO_BEG 17'h0fb00
`define SZBT_IO_END 17'h0fb16
`define SZBT_PER1_BEG 17'h0fc00
`define SZBT_PER1_END 17'h0ffff

// ==========================================
// Fixed access lengths in clock cycles
`define SZBT_RAM_CYC 5'd1
`define SZBT_EEP_FAST_CYC 5'd1
`define SZBT_EEP_SLOW_CYC 5'd2
`define SZBT_PER_CYC 5'd2
`define SZBT_IO_BASE_CYC 5'd3
`define SZBT_NORM_BASE_CYC 5'd2
`define SZBT_FAST_CYC 5'd1

`endif

// File: design/szbt_pkg.sv
// Types shared by the static zone bus timing block
// Assumes szbt_regs.svh sits on the include path
package szbt_pkg;

   // ==========================================
   // Zone that an access falls into
   typedef enum logic [2:0] {
      SZBT_Z_FLASH,
      SZBT_Z_BOOT,
      SZBT_Z_RAM,
      SZBT_Z_EEP,
      SZBT_Z_PER,
      SZBT_Z_IO,
      SZBT_Z_NONE
   } szbt_zone_type;

   // ==========================================
   // Zone configuration word layout
   typedef struct packed {
      logic [3:0] rsv_hi;
      logic fast_read_enable;
      logic preliminary_idle_enable;
      logic post_idle_enable;
      logic rsv_8;
      logic bus_width_select;
      logic [1:0] rsv_6;
      logic [1:0] hold_count;
      logic [2:0] wait_count;
   } szbt_zcfg_type;

   // ==========================================
   // Core bus request
   typedef struct packed {
      logic req;
      logic wr;
      logic [16:0] addr;
      logic [15:0] wdata;
   } szbt_req_type;

   // ==========================================
   // Memory side strobe
   typedef struct packed {
      logic sel;
      logic wr;
      logic [16:0] addr;
      logic [15:0] wdata;
      szbt_zone_type zone;
   } szbt_mem_type;

endpackage

// File: design/szbt_timing.sv
// Static zone bus timing: stretches core-bus accesses per zone
// Assumes a core master that holds its request until done, one clock
// How it works
// - Zone access adds internal wait cycles equal to the 3-bit wait count.
// - Zone access adds hold cycles at its end equal to the 2-bit hold count.
// - With zone 0 fast read set, wait and hold counts are ignored.
// - Zone 0 bus width bit drives bus_width_16: 0 selects 8-bit zone bus, 1 selects 16-bit.
// - Fast read completes reads in one clock; normal reads take two or more.
// - Post-idle set adds two idle cycles (ST_POST, then ST_IDLE) after a cycle when zone changes.
// - Preliminary-idle set adds one idle cycle before a cycle in a new zone.
// - Both zone configuration registers reset to 069f hex.
// - Flash at 0000-bfff and 1c000-1ffff is zone 0, timed by its register.
// - Fast-read zone 0 flash reads finish in one cycle.
// - Normal zone 0 reads add one plus wait count waits, and hold count holds.
// - Fast-read zone 0 writes get one wait with early write, none with late, and no holds.
// - Normal zone 0 writes add wait plus one (late) or two (early), plus holds.
// - Zone 0 write length: two plus early, wait, hold; or one plus early.
// - Static RAM at c000-cbff always completes in one cycle.
// - Data EEPROM at f000-f27f: one cycle if zero-wait, else two; no holds.
// - Peripherals take two cycles with one preliminary idle and no holds.
// - Port B/C range takes three plus I/O wait and hold, writes add early.
// - Early write bit: 0 late, 1 early; resets to early.
// - I/O zone register has wait, hold, width, post-idle; resets 069f hex.
`timescale 1ns/1ps
`include "szbt_regs.svh"

module szbt_timing import szbt_pkg::*; #(
   parameter int ADDR_W = 17
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Core bus
   input wire szbt_req_type core_req,
   output szbt_mem_type mem_req,
   output logic core_done,
   output logic [15:0] core_rdata,
   // Memory side
   input wire logic [15:0] mem_rdata,
   input wire logic zero_wait_state_select,
   // Configuration view
   output logic bus_width_16,
   output logic busy
);

   typedef enum {ST_IDLE, ST_PRE, ST_ACC, ST_POST} szbt_state_type;

   szbt_zcfg_type zone0_timing_config_r;
   szbt_zcfg_type zone1_timing_config_r;
   szbt_zcfg_type io_zone_timing_config_r;
   logic [7:0] bus_unit_config_r;
   szbt_state_type state_r;
   szbt_zone_type last_zone_r;
   szbt_zone_type cur_zone;
   logic [4:0] cnt_r;
   logic [4:0] len;
   logic pre_idle;
   logic post_idle_r;
   logic early_write_select;
   logic reg_hit;
   logic [15:0] reg_rdata;

   assign early_write_select = bus_unit_config_r[`SZBT_EWR_BIT];

   // ==========================================
   // Address decode
   function automatic szbt_zone_type decode(input logic [16:0] a);
      if (a <= `SZBT_FLASH_LO_END || a >= `SZBT_FLASH_HI_BEG) begin
         return SZBT_Z_FLASH;
      end
      if (a >= `SZBT_RAM_BEG && a <= `SZBT_RAM_END) begin
         return SZBT_Z_RAM;
      end
      if (a >= `SZBT_BOOT_BEG && a <= `SZBT_BOOT_END) begin
         return SZBT_Z_BOOT;
      end
      if (a >= `SZBT_EEP_BEG && a <= `SZBT_EEP_END) begin
         return SZBT_Z_EEP;
      end
      if (a >= `SZBT_IO_BEG && a <= `SZBT_IO_END) begin
         return SZBT_Z_IO;
      end
      if ((a >= `SZBT_PER0_BEG && a <= `SZBT_PER0_END) ||
          (a >= `SZBT_PER1_BEG && a <= `SZBT_PER1_END)) begin
         return SZBT_Z_PER;
      end
      return SZBT_Z_NONE;
   endfunction

   // Cycles of a configurable zone in normal mode
   function automatic logic [4:0] zone_len(input szbt_zcfg_type c, input logic wr,
                                           input logic e);
      logic [4:0] n;
      n = `SZBT_NORM_BASE_CYC + {2'b00, c.wait_count} + {3'b000, c.hold_count};
      if (wr) begin
         n = n + {4'b0000, e};
      end
      return n;
   endfunction

   // ==========================================
   // Access length per zone
   always_comb begin
      cur_zone = decode(core_req.addr);
      len = `SZBT_RAM_CYC;
      pre_idle = 1'b0;
      case (cur_zone)
         SZBT_Z_FLASH: begin
            if (zone0_timing_config_r.fast_read_enable) begin
               len = `SZBT_FAST_CYC + (core_req.wr ? {4'b0000, early_write_select} : 5'd0);
            end else begin
               len = zone_len(zone0_timing_config_r, core_req.wr, early_write_select);
            end
            pre_idle = zone0_timing_config_r.preliminary_idle_enable;
         end
         SZBT_Z_BOOT: begin
            if (zone0_timing_config_r.fast_read_enable) begin
               len = `SZBT_FAST_CYC + (core_req.wr ? {4'b0000, early_write_select} : 5'd0);
            end else begin
               len = zone_len(zone1_timing_config_r, core_req.wr, early_write_select);
            end
            pre_idle = zone1_timing_config_r.preliminary_idle_enable;
         end
         SZBT_Z_RAM: len = `SZBT_RAM_CYC;
         SZBT_Z_EEP: begin
            len = zero_wait_state_select ? `SZBT_EEP_FAST_CYC : `SZBT_EEP_SLOW_CYC;
         end
         SZBT_Z_PER: begin
            len = `SZBT_PER_CYC;
            pre_idle = 1'b1;
         end
         SZBT_Z_IO: begin
            len = `SZBT_IO_BASE_CYC + {2'b00, io_zone_timing_config_r.wait_count} +
                  {3'b000, io_zone_timing_config_r.hold_count} +
                  (core_req.wr ? {4'b0000, early_write_select} : 5'd0);
         end
         default: len = `SZBT_RAM_CYC;
      endcase
      pre_idle = pre_idle && (cur_zone != last_zone_r);
   end

   // ==========================================
   // Register file
   assign reg_hit = core_req.addr == `SZBT_EWR_OFS || core_req.addr == `SZBT_IO_ZONE_TIMING_CONFIG_OFS ||
                    core_req.addr == `SZBT_Z0CFG_OFS || core_req.addr == `SZBT_Z1CFG_OFS;

   always_comb begin
      case (core_req.addr)
         `SZBT_EWR_OFS: reg_rdata = {8'h00, bus_unit_config_r};
         `SZBT_IO_ZONE_TIMING_CONFIG_OFS: reg_rdata = io_zone_timing_config_r;
         `SZBT_Z0CFG_OFS: reg_rdata = zone0_timing_config_r;
         `SZBT_Z1CFG_OFS: reg_rdata = zone1_timing_config_r;
         default: reg_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         zone0_timing_config_r <= `SZBT_ZCFG_RST;
         zone1_timing_config_r <= `SZBT_ZCFG_RST;
         io_zone_timing_config_r <= `SZBT_ZCFG_RST;
         bus_unit_config_r <= `SZBT_EWR_RST;
      end else if (state_r == ST_ACC && cnt_r == 5'd1 && core_req.wr) begin
         // Reserved bits are kept at zero regardless of software
         case (core_req.addr)
            `SZBT_EWR_OFS: bus_unit_config_r <= core_req.wdata[7:0] & 8'h07;
            `SZBT_IO_ZONE_TIMING_CONFIG_OFS: io_zone_timing_config_r <= core_req.wdata & 16'h029f;
            `SZBT_Z0CFG_OFS: zone0_timing_config_r <= core_req.wdata & `SZBT_ZCFG_WMASK;
            `SZBT_Z1CFG_OFS: zone1_timing_config_r <= core_req.wdata & `SZBT_ZCFG_WMASK;
            default: ;
         endcase
      end
   end

   // ==========================================
   // Bus cycle sequencer
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         cnt_r <= 5'd0;
         last_zone_r <= SZBT_Z_NONE;
         post_idle_r <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (core_req.req) begin
                  if (post_idle_r && decode(core_req.addr) != last_zone_r) begin
                     state_r <= ST_POST;
                  end else if (pre_idle) begin
                     state_r <= ST_PRE;
                  end else begin
                     state_r <= ST_ACC;
                     cnt_r <= reg_hit ? `SZBT_PER_CYC : len;
                  end
               end
            end
            ST_POST: begin
               post_idle_r <= 1'b0;
               state_r <= ST_IDLE;
            end
            ST_PRE: begin
               state_r <= ST_ACC;
               cnt_r <= reg_hit ? `SZBT_PER_CYC : len;
               last_zone_r <= cur_zone;
            end
            ST_ACC: begin
               if (cnt_r == 5'd1) begin
                  state_r <= ST_IDLE;
                  last_zone_r <= cur_zone;
                  case (cur_zone)
                     SZBT_Z_FLASH: post_idle_r <= zone0_timing_config_r.post_idle_enable;
                     SZBT_Z_BOOT: post_idle_r <= zone1_timing_config_r.post_idle_enable;
                     SZBT_Z_IO: post_idle_r <= io_zone_timing_config_r.post_idle_enable;
                     default: post_idle_r <= 1'b0;
                  endcase
               end
               cnt_r <= cnt_r - 5'd1;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // Registered outputs
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mem_req <= '0;
         core_done <= 1'b0;
         core_rdata <= 16'h0000;
         busy <= 1'b0;
         bus_width_16 <= 1'b1;
      end else begin
         mem_req.sel <= (state_r == ST_ACC) && !reg_hit && cnt_r != 5'd1;
         mem_req.wr <= core_req.wr;
         mem_req.addr <= core_req.addr;
         mem_req.wdata <= core_req.wdata;
         mem_req.zone <= cur_zone;
         core_done <= (state_r == ST_ACC) && cnt_r == 5'd1;
         core_rdata <= reg_hit ? reg_rdata : mem_rdata;
         busy <= state_r != ST_IDLE;
         bus_width_16 <= zone0_timing_config_r.bus_width_select;
      end
   end

endmodule

// File: bench/szbt_mem_model.sv
// Memory-side partner of the timing block
// Assumes read data is wanted in the same clock as the strobe
`timescale 1ns/1ps

module szbt_mem_model import szbt_pkg::*; (
   // Memory side
   input wire szbt_mem_type mem_req,
   output logic [15:0] mem_rdata
);
   // Inverted address, so a stale or wrong address reads back wrong
   assign mem_rdata = ~mem_req.addr[15:0];
endmodule

// File: bench/szbt_timing_assertions.sv
// Concurrent checks on the timing block ports
// Assumes the bind below and the register header on the include path
`timescale 1ns/1ps
`include "szbt_regs.svh"

module szbt_timing_assertions import szbt_pkg::*; (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Observed ports
   input wire szbt_req_type core_req,
   input wire logic core_done,
   input wire logic zero_wait_state_select,
   input wire logic bus_width_16
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   logic in_ram;
   logic in_eep;
   logic in_per;
   logic z0_wr;
   assign in_ram = core_req.addr >= `SZBT_RAM_BEG && core_req.addr <= `SZBT_RAM_END;
   assign in_eep = core_req.addr >= `SZBT_EEP_BEG && core_req.addr <= `SZBT_EEP_END;
   assign in_per = (core_req.addr >= `SZBT_PER0_BEG && core_req.addr <= `SZBT_PER0_END) ||
                   core_req.addr >= `SZBT_PER1_BEG;
   assign z0_wr = core_done && core_req.wr && core_req.addr == `SZBT_Z0CFG_OFS;
   // ==========================================
   // Properties
   property p_rst_width;
      $rose(rst_n) |-> bus_width_16;
   endproperty
   a_rst_width: assert property (p_rst_width) else $error("width not 16 after reset");
   property p_width_copy;
      z0_wr |=> ##1 (bus_width_16 == $past(core_req.wdata[7], 2));
   endproperty
   a_width_copy: assert property (p_width_copy) else $error("width bit not copied");
   property p_done_pulse;
      core_done |=> !core_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
   property p_done_req;
      core_done |-> $past(core_req.req);
   endproperty
   a_done_req: assert property (p_done_req) else $error("done without request");
   property p_ram_fast;
      $rose(core_req.req) && in_ram |-> ##[1:4] core_done;
   endproperty
   a_ram_fast: assert property (p_ram_fast) else $error("ram access too long");
   property p_max_len;
      $rose(core_req.req) |-> ##[1:16] core_done;
   endproperty
   a_max_len: assert property (p_max_len) else $error("access beyond longest length");
   property p_per_min;
      $rose(core_req.req) && in_per |=> ##1 !core_done;
   endproperty
   a_per_min: assert property (p_per_min) else $error("peripheral access too short");
   property p_eep_slow;
      $rose(core_req.req) && in_eep && !zero_wait_state_select |=> ##1 !core_done;
   endproperty
   a_eep_slow: assert property (p_eep_slow) else $error("slow eeprom access too short");
endmodule

bind szbt_timing szbt_timing_assertions u_chk (
   .mclk(mclk),
   .rst_n(rst_n),
   .core_req(core_req),
   .core_done(core_done),
   .zero_wait_state_select(zero_wait_state_select),
   .bus_width_16(bus_width_16)
);

// File: bench/testbench.sv
// Self-checking bench for the static zone bus timing block
// Assumes the package, register header, partner model and checker
`timescale 1ns/1ps
`include "szbt_regs.svh"

module testbench import szbt_pkg::*;;
   logic mclk;
   logic rst_n;
   szbt_req_type core_req;
   szbt_mem_type mem_req;
   logic core_done;
   logic [15:0] core_rdata;
   logic [15:0] mem_rdata;
   logic zws;
   logic bw16;
   logic bsy;
   int nsel;
   int n_fail = 0;
   int checks_done = 0;
   int cyc;
   logic [15:0] rd;
   int wv[3] = '{0, 7, 3};
   int hv[3] = '{0, 3, 1};

   szbt_timing u_dut (.mclk(mclk), .rst_n(rst_n), .core_req(core_req), .mem_req(mem_req),
      .core_done(core_done), .core_rdata(core_rdata), .mem_rdata(mem_rdata),
      .zero_wait_state_select(zws), .bus_width_16(bw16), .busy(bsy));
   szbt_mem_model u_mem (.mem_req(mem_req), .mem_rdata(mem_rdata));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ==========================================
   // Tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One access, held until done; cyc counts edges from the taking edge
   task automatic acc(input logic wr, input logic [16:0] a, input logic [15:0] d);
      int k;
      @(negedge mclk);
      core_req = '{req: 1'b1, wr: wr, addr: a, wdata: d};
      cyc = 0;
      nsel = 0;
      for (k = 0; k < 40 && core_done !== 1'b1; k++) begin
         @(posedge mclk);
         #1;
         cyc++;
         if (mem_req.sel === 1'b1) begin
            nsel++;
         end
      end
      check("done", core_done, 1'b1);
      check("busy", bsy, 1'b1);
      rd = core_rdata;
      @(negedge mclk);
      core_req.req = 1'b0;
   endtask
   // Second of two same-zone accesses, so no idle cycle is counted
   task automatic timed(input logic wr, input logic [16:0] a, input int n);
      acc(wr, a, 16'h0000);
      acc(wr, a, 16'h0000);
      check("cycles", cyc, n + 1);
      check("strobe cycles", nsel, n - 1);
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ==========================================
   // Tests
   initial begin
      int i;
      rst_n = 1'b0;
      core_req = '0;
      zws = 1'b0;
      repeat (12) @(negedge mclk);
      rst_n = 1'b1;
      check("width at reset", bw16, 1'b1);
      check("busy at reset", bsy, 1'b0);
      for (i = 0; i < 4; i++) begin
         acc(1'b0, `SZBT_EWR_OFS + 17'(2 * i), 16'h0000);
         check("reset value", rd, i == 0 ? 16'h0007 : 16'h069f);
      end
      acc(1'b1, `SZBT_Z0CFG_OFS, 16'hffff);
      acc(1'b0, `SZBT_Z0CFG_OFS, 16'h0000);
      check("masked bits", rd, 16'h0e9f);
      acc(1'b1, `SZBT_Z0CFG_OFS, 16'h0000);
      acc(1'b0, `SZBT_Z1CFG_OFS, 16'h0000);
      check("width 8", bw16, 1'b0);
      acc(1'b1, `SZBT_EWR_OFS, 16'h0006);
      for (i = 0; i < 3; i++) begin
         acc(1'b1, `SZBT_Z0CFG_OFS, 16'h0080 | 16'(hv[i] << 3) | 16'(wv[i]));
         acc(1'b1, `SZBT_Z1CFG_OFS, 16'h0080 | 16'(hv[i] << 3) | 16'(wv[i]));
         acc(1'b1, `SZBT_IO_ZONE_TIMING_CONFIG_OFS, 16'h0080 | 16'(hv[i] << 3) | 16'(wv[i]));
         timed(1'b0, 17'h00100, 2 + wv[i] + hv[i]);
         timed(1'b1, 17'h1c000, 2 + wv[i] + hv[i]);
         timed(1'b0, 17'h0e000, 2 + wv[i] + hv[i]);
         timed(1'b0, 17'h0fb00, 3 + wv[i] + hv[i]);
      end
      acc(1'b1, `SZBT_EWR_OFS, 16'h0007);
      timed(1'b1, 17'h00200, 7);
      timed(1'b1, 17'h0fb10, 8);
      acc(1'b1, `SZBT_Z0CFG_OFS, 16'h089f);
      timed(1'b0, 17'h00100, 1);
      timed(1'b1, 17'h00100, 2);
      timed(1'b0, 17'h0e000, 1);
      acc(1'b1, `SZBT_EWR_OFS, 16'h0006);
      timed(1'b1, 17'h00100, 1);
      timed(1'b0, 17'h0c010, 1);
      check("ram data", rd, 16'h3fef);
      timed(1'b1, 17'h0cbfe, 1);
      timed(1'b0, 17'h0f000, 2);
      zws = 1'b1;
      timed(1'b1, 17'h0f27e, 1);
      timed(1'b0, 17'h0f800, 2);
      timed(1'b1, 17'h0fc00, 2);
      acc(1'b1, `SZBT_Z0CFG_OFS, 16'h0480);
      acc(1'b0, 17'h0c000, 16'h0000);
      acc(1'b0, 17'h00100, 16'h0000);
      check("pre idle", cyc, 4);
      acc(1'b1, `SZBT_Z0CFG_OFS, 16'h0280);
      acc(1'b0, 17'h00100, 16'h0000);
      acc(1'b0, 17'h0c000, 16'h0000);
      check("post idle", cyc, 4);
      finish_test();
   end

   initial begin
      #200000;
      n_fail++;
      finish_test();
   end
endmodule
